// [hw/acs_pkg.sv]
// Constants, field layouts and types shared by the converter channel sequencer.
// Assumes one system clock; the serial link pins are sampled, not used as clocks.
//
// How it works
// - Coding bit picks straight binary or twos complement.
// - Code steps are one reference fraction per resolution.
// - Range bit high gives single span, low double.
// - Double span twos complement centres zero at reference.
// - Word: zero, channel tag, then result bits.
// - Ten-bit result gets two trailing zeros.
// - Eight-bit result gets four trailing zeros.
// - Outside sequencing, address bits select one channel.
// - After list load, convert lowest listed channel; the code takes the first listed slot, group one before group two.
// - Each transfer then converts next higher listed channel; the code takes the next listed slot, restarting low in group two.
// - After last listed channel, wrap to first.
// - Writes with sequence bits one-zero keep sequence running.
// - Any other sequence bit pair ends sequence.
// - Sequence bits one-one start consecutive mode directly.
// - Consecutive mode runs channel zero to address.
// - Consecutive mode wraps to zero after final channel.
// - Write bit loads control from first twelve bits.
// - Every transfer needs all sixteen serial clocks.
// - List has two groups; empty second is skipped.
// - Both sequence bits zero: plain addressed conversions.
`default_nettype none

package acs_pkg;
    localparam int          WORD_BITS    = 16;
    localparam int          MAX_RES      = 12;
    localparam int          CHAN_BITS    = 3;
    localparam int          POS_BITS     = 4;
    localparam logic [4:0]  XFER_EDGES   = 5'h10;  // Falling serial edges per transfer.
    localparam logic [4:0]  CODE_CAP_CNT = 5'h02;  // Edge count at which the result is taken.
    localparam int          RX_CTRL_LSB  = 4;      // Control word sits in the first twelve bits.
    // Field positions inside the received 16-bit word, first bit in at bit 15.
    localparam int          F_WRITE      = 15;
    localparam int          F_AUTO_CYCLE = 14;
    localparam int          F_CHAN_HI    = 12;
    localparam int          F_CHAN_LO    = 10;
    localparam int          F_PM_HI      = 9;
    localparam int          F_PM_LO      = 8;
    localparam int          F_LIST_SEL   = 7;
    localparam int          F_RANGE      = 5;
    localparam int          F_CODING     = 4;
    // Result word layout.
    localparam int          W_TAG_HI     = 14;
    localparam int          W_TAG_LO     = 12;
    localparam int          W_CODE_HI    = 11;
    localparam logic [CHAN_BITS-1:0] CHAN_FIRST = 3'h0;
    localparam logic [1:0]  PM_RESET     = 2'h3;
    localparam logic        RANGE_RESET  = 1'b0;
    localparam logic        CODING_RESET = 1'b0;

    typedef enum logic [1:0] {
        ACS_SINGLE,
        ACS_LIST_LOAD,
        ACS_LIST_RUN,
        ACS_CONSEC
    } acs_mode_t;
endpackage : acs_pkg

`default_nettype wire

// [hw/acs_seq_if.sv]
// Carrier between the serial front end and the channel sequencer.
// Assumes both ends run on the system clock.
`default_nettype none

interface acs_seq_if;
    import acs_pkg::*;
    logic                  xfer_done;  // One-cycle pulse after the sixteenth serial edge.
    logic [WORD_BITS-1:0]  rx_word;    // Word received in that transfer.
    logic [CHAN_BITS-1:0]  cur_chan;   // Channel for the next conversion.
    logic                  list_load;  // Next transfer carries the channel list.
    logic                  seq_active; // An automatic sequence is running.

    modport front (output xfer_done, output rx_word, input cur_chan, input list_load, input seq_active);
    modport seq   (input xfer_done, input rx_word, output cur_chan, output list_load, output seq_active);
endinterface : acs_seq_if

`default_nettype wire

// [hw/acs_seq.sv]
// Channel sequencer: mode, channel list, list position and next channel.
// Assumes xfer_done pulses once per complete transfer with rx_word valid.
`default_nettype none

module acs_seq
    import acs_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic resetn_in,
    acs_seq_if.seq    sq
);
    import acs_pkg::*;

    acs_mode_t              mode_r;
    logic [WORD_BITS-1:0]   list_r;
    logic [POS_BITS-1:0]    pos_r;
    logic [CHAN_BITS-1:0]   last_r;
    logic [CHAN_BITS-1:0]   chan_r;
    logic                   wr;
    logic                   auto_bit;
    logic                   sel_bit;
    logic [CHAN_BITS-1:0]   addr;
    logic [POS_BITS-1:0]    nxt_pos;
    logic [POS_BITS-1:0]    first_pos;

    // Next listed slot after pos, wrapping; slot i is list bit 15-i, channel i mod 8.
    function automatic logic [POS_BITS-1:0] next_set(input logic [WORD_BITS-1:0] lst,
                                                      input logic [POS_BITS-1:0]  pos);
        logic [POS_BITS-1:0] idx;
        logic [POS_BITS-1:0] res;
        logic                found;
        res   = pos;
        found = 1'b0;
        for (int k = 1; k <= WORD_BITS; k++) begin
            idx = pos + k[POS_BITS-1:0];
            if (!found && lst[WORD_BITS-1-int'(idx)]) begin
                res   = idx;
                found = 1'b1;
            end
        end
        return res;
    endfunction : next_set

    // Field decode of the received word.
    assign wr        = sq.rx_word[F_WRITE];
    assign auto_bit  = sq.rx_word[F_AUTO_CYCLE];
    assign sel_bit   = sq.rx_word[F_LIST_SEL];
    assign addr      = sq.rx_word[F_CHAN_HI:F_CHAN_LO];
    assign nxt_pos   = next_set(list_r, pos_r);
    assign first_pos = next_set(sq.rx_word, {POS_BITS{1'b1}});

    // Mode and position move only on a finished transfer, so an aborted frame leaves them alone.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_r <= ACS_SINGLE;
            list_r <= '0;
            pos_r  <= '0;
            last_r <= CHAN_FIRST;
            chan_r <= CHAN_FIRST;
        end else if (sq.xfer_done) begin
            if (mode_r == ACS_LIST_LOAD) begin
                // This transfer carried the list, not a control word.
                list_r <= sq.rx_word;
                pos_r  <= first_pos;
                chan_r <= first_pos[CHAN_BITS-1:0];
                mode_r <= ACS_LIST_RUN;
            end else if (wr && !(auto_bit && !sel_bit)) begin
                unique case ({auto_bit, sel_bit})
                    2'b01: begin
                        mode_r <= ACS_LIST_LOAD;
                        chan_r <= addr;
                    end
                    2'b11: begin
                        mode_r <= ACS_CONSEC;
                        last_r <= addr;
                        chan_r <= CHAN_FIRST;
                    end
                    default: begin
                        mode_r <= ACS_SINGLE;
                        chan_r <= addr;
                    end
                endcase
            end else begin
                // No write, or a write that keeps the sequence going.
                unique case (mode_r)
                    ACS_LIST_RUN: begin
                        pos_r  <= nxt_pos;
                        chan_r <= nxt_pos[CHAN_BITS-1:0];
                    end
                    ACS_CONSEC: begin
                        chan_r <= (chan_r >= last_r) ? CHAN_FIRST : chan_r + 3'h1;
                    end
                    default: begin
                        // A one-zero write outside a sequence just picks the addressed channel.
                        if (wr) begin
                            chan_r <= addr;
                        end
                    end
                endcase
            end
        end
    end

    assign sq.cur_chan   = chan_r;
    assign sq.list_load  = (mode_r == ACS_LIST_LOAD);
    assign sq.seq_active = (mode_r == ACS_LIST_RUN) || (mode_r == ACS_CONSEC);
endmodule : acs_seq

`default_nettype wire

// [hw/acs_top.sv]
// Digital side of an eight-channel converter: serial link, control word, result word, sequencer.
// Assumes the analog front end presents a straight-binary code on raw_code_in and holds it
// from sample_out until at least the third serial falling edge of the frame.
`default_nettype none

module acs_top
    import acs_pkg::*;
#(
    parameter int RES_BITS = 12   // 8, 10 or 12.
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  resetn_in,
    input  wire logic                  cs_n_in,
    input  wire logic                  sclk_in,
    input  wire logic                  din_in,
    input  wire logic [RES_BITS-1:0]   raw_code_in,
    output var  logic                  dout_out,
    output var  logic                  dout_oe_out,
    output var  logic                  sample_out,
    output var  logic [CHAN_BITS-1:0]  mux_sel_out,
    output var  logic                  range_sel_out,
    output var  logic                  coding_twos_out,
    output var  logic [1:0]            power_mode_out,
    output var  logic                  seq_active_out
);
    import acs_pkg::*;

    acs_seq_if sq ();

    logic [2:0]             cs_sync_r;
    logic [2:0]             sclk_sync_r;
    logic [2:0]             din_sync_r;
    logic                   cs_n_f_r;
    logic                   sclk_f_r;
    logic                   din_f_r;
    logic                   cs_fall;
    logic                   sclk_fall;
    logic                   frame_r;
    logic [4:0]             cnt_r;
    logic [4:0]             cnt_nxt;
    logic [WORD_BITS-1:0]   rx_r;
    logic [WORD_BITS-1:0]   word_r;
    logic                   done_r;
    logic [WORD_BITS-1:0]   rx_nxt;

    // Places the result after the tag, left justified, with the chosen coding.
    function automatic logic [MAX_RES-1:0] fmt_code(input logic [RES_BITS-1:0] raw,
                                                     input logic              twos);
        logic [RES_BITS-1:0] c;
        logic [MAX_RES:0]    wide;
        c = raw;
        if (twos) begin
            c[RES_BITS-1] = ~raw[RES_BITS-1];
        end
        // One spare zero keeps the fill non-empty at full resolution; it is cut off again here.
        wide = {c, {(MAX_RES-RES_BITS+1){1'b0}}};
        return wide[MAX_RES:1];
    endfunction : fmt_code

    // Three-stage samplers; a pin value counts only once stages two and three agree.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cs_sync_r   <= 3'h7;
            sclk_sync_r <= 3'h7;
            din_sync_r  <= 3'h0;
        end else begin
            cs_sync_r   <= {cs_sync_r[1:0], cs_n_in};
            sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
            din_sync_r  <= {din_sync_r[1:0], din_in};
        end
    end

    // Filtered pin levels; edges are taken from changes of these.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cs_n_f_r <= 1'b1;
            sclk_f_r <= 1'b1;
            din_f_r  <= 1'b0;
        end else begin
            if (cs_sync_r[2] == cs_sync_r[1]) begin
                cs_n_f_r <= cs_sync_r[2];
            end
            if (sclk_sync_r[2] == sclk_sync_r[1]) begin
                sclk_f_r <= sclk_sync_r[2];
            end
            if (din_sync_r[2] == din_sync_r[1]) begin
                din_f_r <= din_sync_r[2];
            end
        end
    end

    assign cs_fall   = cs_n_f_r && (cs_sync_r[2] == cs_sync_r[1]) && !cs_sync_r[2];
    assign sclk_fall = sclk_f_r && (sclk_sync_r[2] == sclk_sync_r[1]) && !sclk_sync_r[2];
    assign cnt_nxt   = cnt_r + 5'h01;
    assign rx_nxt    = {rx_r[WORD_BITS-2:0], din_f_r};

    // Frame tracking and bit counter; chip select rising drops any unfinished frame.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_r <= 1'b0;
            cnt_r   <= '0;
        end else if (cs_fall) begin
            frame_r <= 1'b1;
            cnt_r   <= '0;
        end else if (cs_n_f_r) begin
            frame_r <= 1'b0;
        end else if (frame_r && sclk_fall && cnt_r < XFER_EDGES) begin
            cnt_r <= cnt_nxt;
            if (cnt_nxt == XFER_EDGES) begin
                frame_r <= 1'b0;
            end
        end
    end

    // Receive shift register, first bit in ends up at the top.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_r <= '0;
        end else if (frame_r && !cs_n_f_r && sclk_fall) begin
            rx_r <= rx_nxt;
        end
    end

    // Completion pulse only after the sixteenth edge; short frames never reach it.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_r <= 1'b0;
        end else begin
            done_r <= frame_r && !cs_n_f_r && sclk_fall && (cnt_nxt == XFER_EDGES);
        end
    end

    assign sq.xfer_done = done_r;
    assign sq.rx_word   = rx_r;

    // Result word: tag latched at the frame start, code taken a few edges later.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_r <= '0;
        end else if (cs_fall) begin
            word_r <= {1'b0, sq.cur_chan, {MAX_RES{1'b0}}};
        end else if (frame_r && sclk_fall && cnt_r == CODE_CAP_CNT) begin
            word_r[W_CODE_HI:0] <= fmt_code(raw_code_in, coding_twos_out);
        end
    end

    // Serial output: first bit on the select edge, then one per falling serial edge.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dout_out    <= 1'b0;
            dout_oe_out <= 1'b0;
        end else if (cs_fall) begin
            dout_out    <= 1'b0;
            dout_oe_out <= 1'b1;
        end else if (cs_n_f_r) begin
            dout_out    <= 1'b0;
            dout_oe_out <= 1'b0;
        end else if (frame_r && sclk_fall) begin
            if (cnt_nxt == XFER_EDGES) begin
                dout_out    <= 1'b0;
                dout_oe_out <= 1'b0;
            end else begin
                dout_out <= word_r[WORD_BITS-1-int'(cnt_nxt)];
            end
        end
    end

    // Sample strobe towards the front end, and the selected channel at that moment.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sample_out  <= 1'b0;
            mux_sel_out <= CHAN_FIRST;
        end else begin
            sample_out <= cs_fall;
            if (!frame_r) begin
                mux_sel_out <= sq.cur_chan;
            end
        end
    end

    // Control fields; a list-load transfer carries no control word.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            range_sel_out   <= RANGE_RESET;
            coding_twos_out <= CODING_RESET;
            power_mode_out  <= PM_RESET;
        end else if (done_r && !sq.list_load && rx_r[F_WRITE]) begin
            range_sel_out   <= rx_r[F_RANGE];
            coding_twos_out <= rx_r[F_CODING];
            power_mode_out  <= rx_r[F_PM_HI:F_PM_LO];
        end
    end

    // Sequence status mirrors the sequencer one cycle late so it comes from a flop.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seq_active_out <= 1'b0;
        end else begin
            seq_active_out <= sq.seq_active;
        end
    end

    acs_seq u_seq (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .sq         (sq.seq)
    );
endmodule : acs_top

`default_nettype wire

// [test/acs_top_chk.sv]
// Concurrent checks on the converter top-level pins.
// Assumes one system clock domain and the asynchronous active-low reset.
`default_nettype none

module acs_top_chk
    import acs_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    input wire logic                 clk_sys_in,
    input wire logic                 resetn_in,
    input wire logic                 cs_n_in,
    input wire logic                 sclk_in,
    input wire logic                 din_in,
    input wire logic [RES_BITS-1:0]  raw_code_in,
    input wire logic                 dout_out,
    input wire logic                 dout_oe_out,
    input wire logic                 sample_out,
    input wire logic [CHAN_BITS-1:0] mux_sel_out,
    input wire logic                 range_sel_out,
    input wire logic                 coding_twos_out,
    input wire logic [1:0]           power_mode_out,
    input wire logic                 seq_active_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import acs_pkg::*;

    // All checks share the system clock and drop out while reset is low.
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    oe_start_a: assert property ($fell(cs_n_in) |-> ##[1:8] dout_oe_out)
        else $error("Output enable did not follow the select.");
    oe_stop_a: assert property (cs_n_in [*8] |-> !dout_oe_out)
        else $error("Output still driven with the select high.");
    sample_start_a: assert property ($fell(cs_n_in) |-> ##[1:8] sample_out)
        else $error("No sample pulse after the select fell.");
    sample_once_a: assert property (sample_out |=> (!sample_out) [*4])
        else $error("Sample pulse longer than one cycle.");
    lead_zero_a: assert property ($rose(dout_oe_out) |-> !dout_out)
        else $error("Result word does not start with zero.");
    mux_hold_a: assert property (dout_oe_out |-> $stable(mux_sel_out))
        else $error("Channel changed inside a transfer.");
    range_hold_a: assert property (dout_oe_out |-> $stable(range_sel_out))
        else $error("Span select changed inside a transfer.");
    coding_hold_a: assert property (dout_oe_out |-> $stable(coding_twos_out))
        else $error("Coding changed inside a transfer.");
    power_hold_a: assert property (dout_oe_out |-> $stable(power_mode_out))
        else $error("Power field changed inside a transfer.");
    seq_hold_a: assert property (dout_oe_out |-> $stable(seq_active_out))
        else $error("Sequence flag changed inside a transfer.");
endmodule : acs_top_chk

bind acs_top acs_top_chk #(.RES_BITS(RES_BITS)) chk_i (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
    .din_in(din_in), .raw_code_in(raw_code_in), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
    .sample_out(sample_out), .mux_sel_out(mux_sel_out), .range_sel_out(range_sel_out),
    .coding_twos_out(coding_twos_out), .power_mode_out(power_mode_out), .seq_active_out(seq_active_out)
);

`default_nettype wire

// [test/acs_host_model.sv]
// Behavioural host serial master for the converter link.
// Assumes the bench calls frame once at a time, clocked by the system clock.
`default_nettype none

module acs_host_model (
    input  wire logic clk_in,
    input  wire logic dout_in,
    input  wire logic dout_oe_in,
    output var  logic cs_n_out,
    output var  logic sclk_out,
    output var  logic din_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_r = 1'b0;
    logic line;

    // A released output shows the inverse of its last bit, so stale data never matches.
    always @(posedge clk_in) if (dout_oe_in) last_r <= dout_in;
    assign line = dout_oe_in ? dout_in : ~last_r;

    // Serial clock idles high and stands still outside frames.
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out  = 1'b0;
    end

    // One transfer; fewer than sixteen edges aborts it early.
    task automatic frame(input logic [15:0] tx, input int edges, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk_in) #2 cs_n_out = 1'b0;
        din_out = tx[15];
        repeat (8) @(posedge clk_in);
        #2;
        for (int i = 15; i > 15 - edges; i--) begin
            rx[i] = line;
            sclk_out = 1'b0;
            repeat (4) @(posedge clk_in);
            #2 sclk_out = 1'b1;
            if (i > 0) din_out = tx[i-1];
            repeat (4) @(posedge clk_in);
            #2;
        end
        cs_n_out = 1'b1;
        din_out = 1'b0;
        repeat (8) @(posedge clk_in);
        #2;
    endtask : frame
endmodule : acs_host_model

`default_nettype wire

// [test/adc_channel_sequencer_bench.sv]
// Self-checking bench: the host model runs frames and result words are compared.
// Assumes the package, the design, the host model and the bound checker are compiled first.
`default_nettype none

module adc_channel_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import acs_pkg::*;
    logic            clk_sys_in  = 1'b0;
    logic            resetn_in   = 1'b0;
    logic [11:0]     code        = 12'h000;
    logic            tw          = 1'b0;
    logic [2:0]      prev        = 3'h0;
    logic [15:0]     rx;
    logic [15:0]     rx8         = 16'h0000;
    logic [15:0]     rx10        = 16'h0000;
    wire logic       dout8, dout10;
    int              miscompares = 0;
    int              num_checks  = 0;
    wire logic       cs_n, sclk, din, dout, dout_oe, sample, range_sel, coding, seq_act;
    wire logic [2:0] mux;
    wire logic [1:0] pm;

    acs_top #(.RES_BITS(12)) DUT (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din),
        .raw_code_in(code), .dout_out(dout), .dout_oe_out(dout_oe), .sample_out(sample),
        .mux_sel_out(mux), .range_sel_out(range_sel), .coding_twos_out(coding),
        .power_mode_out(pm), .seq_active_out(seq_act)
    );
    acs_host_model host (.clk_in(clk_sys_in), .dout_in(dout), .dout_oe_in(dout_oe), .cs_n_out(cs_n),
        .sclk_out(sclk), .din_out(din));

    // Reduced-resolution copies listen on the same link, fed with the top bits of the same code.
    acs_top #(.RES_BITS(8)) DUT_R8 (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din),
        .raw_code_in(code[11:4]), .dout_out(dout8), .dout_oe_out(), .sample_out(), .mux_sel_out(),
        .range_sel_out(), .coding_twos_out(), .power_mode_out(), .seq_active_out()
    );
    acs_top #(.RES_BITS(10)) DUT_R10 (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din),
        .raw_code_in(code[11:2]), .dout_out(dout10), .dout_oe_out(), .sample_out(), .mux_sel_out(),
        .range_sel_out(), .coding_twos_out(), .power_mode_out(), .seq_active_out()
    );

    // Their words are taken bit by bit at each serial falling edge, as the host does.
    always @(negedge sclk) begin
        rx8  <= {rx8[14:0], dout8};
        rx10 <= {rx10[14:0], dout10};
    end

    initial forever #12.5 clk_sys_in = ~clk_sys_in;

    task automatic conclude;
        if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [15:0] ctl(input logic w, a, input logic [2:0] ch, input logic s, r, c);
        return {w, a, 1'b0, ch, 2'b11, s, 1'b0, r, c, 4'h0};
    endfunction : ctl

    // Coding of a written word takes effect from the following conversion.
    task automatic xf(input logic [15:0] tx, input logic [2:0] tag);
        logic [15:0] want;
        host.frame(tx, 16, rx);
        want = {1'b0, tag, tw ? {~code[11], code[10:0]} : code};
        chk(rx, want);
        chk(rx10, want & 16'hfffc);
        chk(rx8, want & 16'hfff0);
        if (tx[15] === 1'b1) tw = tx[4];
        code = code + 12'h351;
    endtask : xf

    // A hang counts as a mismatch; the frames need about four thousand four hundred cycles.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge clk_sys_in);
        #2 resetn_in = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        chk(16'({mux, range_sel, coding, pm, seq_act}),
            16'({CHAN_FIRST, RANGE_RESET, CODING_RESET, PM_RESET, 1'b0}));
        for (int i = 0; i < 8; i++) begin
            xf(ctl(1'b1, 1'b0, 3'(i), 1'b0, 1'b1, 1'b0), prev);
            prev = 3'(i);
        end
        xf(16'h7fff, 3'h7);
        chk(16'({mux, range_sel, coding, seq_act}), 16'h003c);
        xf(ctl(1'b1, 1'b0, 3'h7, 1'b0, 1'b0, 1'b1), 3'h7);
        code = 12'h800;
        xf(16'h0000, 3'h7);
        chk(16'({range_sel, coding}), 16'h0001);
        xf(16'h9e10, 3'h7);
        chk(16'(pm), 16'h0002);
        xf(ctl(1'b1, 1'b0, 3'h2, 1'b1, 1'b1, 1'b0), 3'h7);
        xf(16'h2442, 3'h2);
        xf(16'h0000, 3'h2);
        host.frame(16'hffff, 5, rx);
        xf(16'h0000, 3'h5);
        chk(16'(seq_act), 16'h0001);
        xf(ctl(1'b1, 1'b1, 3'h0, 1'b0, 1'b0, 1'b0), 3'h1);
        chk(16'(range_sel), 16'h0000);
        xf(16'h0000, 3'h6);
        xf(16'h0000, 3'h2);
        xf(ctl(1'b1, 1'b0, 3'h3, 1'b0, 1'b1, 1'b0), 3'h5);
        chk(16'(seq_act), 16'h0000);
        xf(ctl(1'b1, 1'b1, 3'h2, 1'b1, 1'b1, 1'b0), 3'h3);
        xf(16'h0000, 3'h0);
        xf(16'h0000, 3'h1);
        xf(16'h0000, 3'h2);
        xf(ctl(1'b1, 1'b1, 3'h2, 1'b0, 1'b1, 1'b0), 3'h0);
        xf(ctl(1'b1, 1'b0, 3'h0, 1'b1, 1'b1, 1'b0), 3'h1);
        xf(16'h1200, 3'h0);
        xf(16'h0000, 3'h3);
        xf(16'h0000, 3'h6);
        xf(16'h0000, 3'h3);
        conclude();
    end
endmodule : adc_channel_sequencer_bench

`default_nettype wire
